/* File: core/rcfg_pkg.sv */
// Shared constants, encodings and carrier types for the radio config bank
package rcfg_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [5:0] OFS_SPC_EXP = 6'h13;
	localparam logic [5:0] OFS_SPC_MAN = 6'h14;
	localparam logic [5:0] OFS_DEV = 6'h15;
	localparam logic [5:0] OFS_CFG_TWO = 6'h16;
	localparam logic [5:0] OFS_CFG_ONE = 6'h17;

	// Reset values
	localparam logic [7:0] RST_SPC_EXP = 8'h02;
	localparam logic [7:0] RST_SPC_MAN = 8'hf8;
	localparam logic [7:0] RST_DEV = 8'h47;
	localparam logic [7:0] RST_CFG_TWO = 8'h07;
	localparam logic [7:0] RST_CFG_ONE = 8'h30;

	// Writable bits; the rest read zero
	localparam logic [7:0] MSK_SPC_EXP = 8'h83;
	localparam logic [7:0] MSK_SPC_MAN = 8'hff;
	localparam logic [7:0] MSK_DEV = 8'h77;
	localparam logic [7:0] MSK_CFG_TWO = 8'h1f;
	localparam logic [7:0] MSK_CFG_ONE = 8'h3f;

	// Field positions
	localparam int SPC_E_LSB = 0;
	localparam int DEV_E_LSB = 4;
	localparam int DEV_M_LSB = 0;
	localparam int TERM_BIT = 4;
	localparam int RXOFF_LSB = 2;

	// Modulation and next-state codes
	localparam logic [2:0] MOD_OOK = 3'h3;
	localparam logic [1:0] RXOFF_IDLE = 2'h0;
	localparam logic [1:0] RXOFF_STAY = 2'h3;

	// Symbols allowed for carrier sense under on-off keying
	localparam logic [3:0] OOK_CS_SYMBOLS = 4'h8;

	// Sync qualifier encodings
	typedef enum logic [2:0] {
		SQ_NONE = 3'b000,
		SQ_15OF16 = 3'b001,
		SQ_16OF16 = 3'b010,
		SQ_30OF32 = 3'b011,
		SQ_CS_ONLY = 3'b100,
		SQ_15OF16_CS = 3'b101,
		SQ_16OF16_CS = 3'b110,
		SQ_30OF32_CS = 3'b111
	} rcfg_sync_mode_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_SEARCH = 2'b01,
		RX_PACKET = 2'b10
	} rcfg_rx_state_e;

	// One register write from the serial port
	typedef struct packed {
		logic en;
		logic [5:0] addr;
		logic [7:0] data;
	} rcfg_wr_s;

	// Radio-facing configuration
	typedef struct packed {
		logic [1:0] spacing_exponent;
		logic [7:0] spacing_mantissa;
		logic [2:0] dev_exponent;
		logic [2:0] dev_mantissa;
		logic dev_enable;
	} rcfg_radio_s;
endpackage

/* File: core/rcfg_spi_slave.sv */
// Serial register port: header byte then data bytes, mode 0
`timescale 1ns/1ps
`default_nettype none
module rcfg_spi_slave (
	input wire logic clk, // System clock
	input wire logic rstn, // Sync reset, active low
	input wire logic csn, // Chip select, active low
	input wire logic sclk, // Serial clock
	input wire logic mosi, // Serial data in
	output logic miso, // Serial data out
	output logic miso_oe, // Drive enable for miso
	output logic [5:0] rd_addr, // Address being read
	input wire logic [7:0] rdata, // Read data for rd_addr
	output rcfg_pkg::rcfg_wr_s wr // One-cycle write request
);
	typedef struct packed {
		logic sclk_q;
		logic [2:0] bit_cnt;
		logic [6:0] shift_in;
		logic [7:0] shift_out;
		logic hdr_done;
		logic rw;
		logic burst;
		logic [5:0] addr;
		logic load;
		logic miso;
		logic miso_oe;
		rcfg_pkg::rcfg_wr_s wr;
	} rcfg_spi_s;

	rcfg_spi_s r;
	rcfg_spi_s next_r;
	logic rise;
	logic fall;
	logic [7:0] byte_in;

	always_comb begin
		next_r = r;
		next_r.sclk_q = sclk;
		next_r.wr.en = 1'b0;
		next_r.load = 1'b0;
		rise = sclk & ~r.sclk_q;
		fall = ~sclk & r.sclk_q;
		byte_in = {r.shift_in, mosi};
		if (csn) begin
			next_r.bit_cnt = 3'h0;
			next_r.hdr_done = 1'b0;
			next_r.miso_oe = 1'b0;
			next_r.miso = 1'b0;
		end else begin
			next_r.miso_oe = 1'b1;
			if (rise) begin
				next_r.shift_in = byte_in[6:0];
				next_r.bit_cnt = r.bit_cnt + 3'h1;
				if (r.bit_cnt == 3'h7) begin
					if (!r.hdr_done) begin
						next_r.rw = byte_in[7];
						next_r.burst = byte_in[6];
						next_r.addr = byte_in[5:0];
						next_r.hdr_done = 1'b1;
						next_r.load = byte_in[7];
					end else begin
						next_r.wr.en = ~r.rw;
						next_r.wr.addr = r.addr;
						next_r.wr.data = byte_in;
						// Without burst the next byte is a fresh header
						next_r.hdr_done = r.burst;
						next_r.addr = r.addr + 6'h1;
						next_r.load = r.rw & r.burst;
					end
				end
			end
			// Byte boundary falls skip the shift so the loaded MSB stays
			if (fall && r.bit_cnt != 3'h0) begin
				next_r.shift_out = {r.shift_out[6:0], 1'b0};
				next_r.miso = r.shift_out[6];
			end
			if (r.load) begin
				next_r.shift_out = rdata;
				next_r.miso = rdata[7];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign miso = r.miso;
	assign miso_oe = r.miso_oe;
	assign rd_addr = r.addr;
	assign wr = r.wr;
endmodule
`default_nettype wire

/* File: core/rcfg_sync_corr.sv */
// Sync word correlator: counts agreeing bits against the pattern
`timescale 1ns/1ps
`default_nettype none
module rcfg_sync_corr #(
	parameter int W = 32
) (
	input wire logic [W-1:0] rx_bits, // Most recent bits, newest in bit 0
	input wire logic [W-1:0] pattern, // Programmed sync pattern
	output logic hit_15of16, // At least 15 of low 16 agree
	output logic hit_16of16, // All of low 16 agree
	output logic hit_30of32 // At least 30 of 32 agree
);
	logic [W-1:0] agree;
	logic [5:0] cnt_lo;
	logic [5:0] cnt_all;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			assign agree[g] = ~(rx_bits[g] ^ pattern[g]);
		end
	endgenerate

	always_comb begin
		cnt_lo = 6'h0;
		cnt_all = 6'h0;
		for (int i = 0; i < W; i++) begin
			cnt_all = cnt_all + {5'h0, agree[i]};
			if (i < 16) begin
				cnt_lo = cnt_lo + {5'h0, agree[i]};
			end
		end
	end

	assign hit_15of16 = cnt_lo >= 6'h0f;
	assign hit_16of16 = cnt_lo == 6'h10;
	assign hit_30of32 = cnt_all >= 6'h1e;
endmodule
`default_nettype wire

/* File: core/rcfg_top.sv */
// Modem and radio-control configuration bank with receive qualifier
`timescale 1ns/1ps
`default_nettype none
module rcfg_top #(
	parameter int SYNC_W = 32,
	parameter int CHANNEL_NUMBER_W = 8,
	parameter int BASE_W = 24
) (
	input wire logic clk, // 20 MHz system clock
	input wire logic rstn, // Sync reset, active low
	input wire logic csn, // Serial chip select, active low
	input wire logic sclk, // Serial clock
	input wire logic mosi, // Serial data in
	output logic miso, // Serial data out
	output logic miso_oe, // Drive enable for miso
	input wire logic [2:0] sync_mode, // Sync qualifier mode
	input wire logic [2:0] mod_format, // Modulation format
	input wire logic [SYNC_W-1:0] sync_word, // Programmed sync pattern
	input wire logic [CHANNEL_NUMBER_W-1:0] channel_number, // Channel index
	input wire logic [BASE_W-1:0] base_freq, // Base frequency word
	input wire logic rx_start, // Pulse: enter receive
	input wire logic demod_valid, // Pulse: one demodulated symbol
	input wire logic demod_bit, // Demodulated bit
	input wire logic carrier_sense, // Carrier sense above threshold
	input wire logic packet_done, // Pulse: packet reception complete
	output rcfg_pkg::rcfg_radio_s radio_cfg, // Modem settings
	output logic [BASE_W+1:0] synth_word, // Synthesizer frequency word
	output logic [1:0] rx_state, // Receive state
	output logic rx_on, // Receiver active
	output logic sync_found, // Pulse: reception qualified
	output logic rx_terminated, // Pulse: carrier-based end of RX
	output logic [1:0] post_receive_next_state // Configured next state
);
	localparam int OFS_W = 12 + CHANNEL_NUMBER_W;

	typedef struct packed {
		logic [7:0] channel_spacing_exponent;
		logic [7:0] channel_spacing_mantissa;
		logic [7:0] frequency_deviation;
		logic [7:0] radio_control_cfg_two;
		logic [7:0] radio_control_cfg_one;
		rcfg_pkg::rcfg_rx_state_e state;
		logic [3:0] sym_cnt;
		logic [SYNC_W-1:0] sync_sr;
		rcfg_pkg::rcfg_radio_s radio;
		logic [BASE_W+1:0] synth;
		logic sync_found;
		logic rx_terminated;
		logic rx_on;
	} rcfg_top_s;

	rcfg_top_s r;
	rcfg_top_s next_r;

	logic [5:0] rd_addr;
	logic [7:0] rdata;
	rcfg_pkg::rcfg_wr_s wr;
	logic hit_15of16;
	logic hit_16of16;
	logic hit_30of32;
	logic [SYNC_W-1:0] sr_next;
	logic sync_ok;
	logic qualified;
	logic is_ook;
	logic term_en;
	logic [1:0] spc_e;
	logic [11:0] spacing;
	logic [OFS_W-1:0] channel_number_ofs;

	rcfg_spi_slave u_spi (
		.clk(clk),
		.rstn(rstn),
		.csn(csn),
		.sclk(sclk),
		.mosi(mosi),
		.miso(miso),
		.miso_oe(miso_oe),
		.rd_addr(rd_addr),
		.rdata(rdata),
		.wr(wr)
	);

	// Looks at the shift register including the bit arriving now
	rcfg_sync_corr #(
		.W(SYNC_W)
	) u_corr (
		.rx_bits(sr_next),
		.pattern(sync_word),
		.hit_15of16(hit_15of16),
		.hit_16of16(hit_16of16),
		.hit_30of32(hit_30of32)
	);

	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (rd_addr)
			rcfg_pkg::OFS_SPC_EXP: rdata = r.channel_spacing_exponent;
			rcfg_pkg::OFS_SPC_MAN: rdata = r.channel_spacing_mantissa;
			rcfg_pkg::OFS_DEV: rdata = r.frequency_deviation;
			rcfg_pkg::OFS_CFG_TWO: rdata = r.radio_control_cfg_two;
			rcfg_pkg::OFS_CFG_ONE: rdata = r.radio_control_cfg_one;
			default: rdata = 8'h00;
		endcase
	end

	always_comb begin
		sr_next = {r.sync_sr[SYNC_W-2:0], demod_bit};
		is_ook = mod_format == rcfg_pkg::MOD_OOK;
		term_en = r.radio_control_cfg_two[rcfg_pkg::TERM_BIT];
		// Sync match per mode; codes 0 and 4 never look at the pattern
		unique case (sync_mode[1:0])
			2'b01: sync_ok = demod_valid & hit_15of16;
			2'b10: sync_ok = demod_valid & hit_16of16;
			2'b11: sync_ok = demod_valid & hit_30of32;
			default: sync_ok = 1'b1;
		endcase
		// Upper mode bit adds the carrier-sense condition
		qualified = sync_ok & (~sync_mode[2] | carrier_sense);
	end

	// Frequency word in units of the crystal over 2^18
	always_comb begin
		spc_e = r.channel_spacing_exponent[rcfg_pkg::SPC_E_LSB +: 2];
		spacing = 12'({1'b1, r.channel_spacing_mantissa}) << spc_e;
		channel_number_ofs = OFS_W'(spacing * channel_number);
	end

	always_comb begin
		next_r = r;
		next_r.sync_found = 1'b0;
		next_r.rx_terminated = 1'b0;

		if (wr.en) begin
			unique case (wr.addr)
				rcfg_pkg::OFS_SPC_EXP: begin
					next_r.channel_spacing_exponent = wr.data & rcfg_pkg::MSK_SPC_EXP;
				end
				rcfg_pkg::OFS_SPC_MAN: begin
					next_r.channel_spacing_mantissa = wr.data & rcfg_pkg::MSK_SPC_MAN;
				end
				rcfg_pkg::OFS_DEV: begin
					next_r.frequency_deviation = wr.data & rcfg_pkg::MSK_DEV;
				end
				rcfg_pkg::OFS_CFG_TWO: begin
					next_r.radio_control_cfg_two = wr.data & rcfg_pkg::MSK_CFG_TWO;
				end
				rcfg_pkg::OFS_CFG_ONE: begin
					next_r.radio_control_cfg_one = wr.data & rcfg_pkg::MSK_CFG_ONE;
				end
				default: begin
				end
			endcase
		end

		next_r.radio.spacing_exponent = spc_e;
		next_r.radio.spacing_mantissa = r.channel_spacing_mantissa;
		// Deviation is masked off under on-off keying
		next_r.radio.dev_enable = ~is_ook;
		next_r.radio.dev_exponent = is_ook ? 3'h0 :
			r.frequency_deviation[rcfg_pkg::DEV_E_LSB +: 3];
		next_r.radio.dev_mantissa = is_ook ? 3'h0 :
			r.frequency_deviation[rcfg_pkg::DEV_M_LSB +: 3];
		next_r.synth = (BASE_W+2)'({base_freq, 2'b00}) + (BASE_W+2)'(channel_number_ofs);

		unique case (r.state)
			rcfg_pkg::RX_IDLE: begin
				if (rx_start) begin
					next_r.state = rcfg_pkg::RX_SEARCH;
					next_r.sym_cnt = 4'h0;
					next_r.sync_sr = '0;
				end
			end
			rcfg_pkg::RX_SEARCH: begin
				if (demod_valid) begin
					next_r.sync_sr = sr_next;
					if (r.sym_cnt != rcfg_pkg::OOK_CS_SYMBOLS) begin
						next_r.sym_cnt = r.sym_cnt + 4'h1;
					end
				end
				if (term_en && is_ook && !carrier_sense && demod_valid &&
					r.sym_cnt == rcfg_pkg::OOK_CS_SYMBOLS - 4'h1) begin
					// No carrier when the eighth symbol arrives: give up
					next_r.state = rcfg_pkg::RX_IDLE;
					next_r.rx_terminated = 1'b1;
				end else if (term_en && !is_ook && !carrier_sense) begin
					next_r.state = rcfg_pkg::RX_IDLE;
					next_r.rx_terminated = 1'b1;
				end else if (qualified) begin
					next_r.state = rcfg_pkg::RX_PACKET;
					next_r.sync_found = 1'b1;
				end
			end
			rcfg_pkg::RX_PACKET: begin
				if (packet_done) begin
					// Reserved codes fall back to idle
					if (r.radio_control_cfg_one[rcfg_pkg::RXOFF_LSB +: 2] ==
						rcfg_pkg::RXOFF_STAY) begin
						next_r.state = rcfg_pkg::RX_SEARCH;
						next_r.sym_cnt = 4'h0;
						next_r.sync_sr = '0;
					end else begin
						next_r.state = rcfg_pkg::RX_IDLE;
					end
				end
			end
			default: begin
				next_r.state = rcfg_pkg::RX_IDLE;
			end
		endcase
		// Registered so the pin does not glitch on state decode
		next_r.rx_on = next_r.state != rcfg_pkg::RX_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			r <= '0;
			r.channel_spacing_exponent <= rcfg_pkg::RST_SPC_EXP;
			r.channel_spacing_mantissa <= rcfg_pkg::RST_SPC_MAN;
			r.frequency_deviation <= rcfg_pkg::RST_DEV;
			r.radio_control_cfg_two <= rcfg_pkg::RST_CFG_TWO;
			r.radio_control_cfg_one <= rcfg_pkg::RST_CFG_ONE;
			r.state <= rcfg_pkg::RX_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign radio_cfg = r.radio;
	assign synth_word = r.synth;
	assign rx_state = r.state;
	assign rx_on = r.rx_on;
	assign sync_found = r.sync_found;
	assign rx_terminated = r.rx_terminated;
	assign post_receive_next_state = r.radio_control_cfg_one[rcfg_pkg::RXOFF_LSB +: 2];
endmodule
`default_nettype wire

/* File: test/rcfg_top_monitor.sv */
// Port checker for the radio configuration bank
`timescale 1ns/1ps
`default_nettype none
module rcfg_top_monitor (
	input wire logic clk, // System clock
	input wire logic rstn, // Sync reset, active low
	input wire logic csn, // Chip select, active low
	input wire logic miso, // Serial data out
	input wire logic miso_oe, // Drive enable for miso
	input wire logic [2:0] mod_format, // Modulation format
	input wire logic rx_start, // Enter receive
	input wire logic packet_done, // Packet complete
	input wire rcfg_pkg::rcfg_radio_s radio_cfg, // Modem settings
	input wire logic [1:0] rx_state, // Receive state
	input wire logic rx_on, // Receiver active
	input wire logic sync_found, // Reception qualified
	input wire logic rx_terminated, // Carrier-based end
	input wire logic [1:0] post_receive_next_state // Configured next state
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_oe_select: assert property (!csn && !$past(csn) |-> miso_oe)
		else $error("miso_oe low while selected");
	a_miso_idle: assert property (csn && $past(csn) |-> !miso_oe && !miso)
		else $error("miso driven while deselected");
	a_rx_on_state: assert property (rx_on == (rx_state != 2'h0))
		else $error("rx_on disagrees with state");
	a_found_pulse: assert property (
		sync_found |-> rx_state == 2'h2 && $past(rx_state) == 2'h1 ##1 !sync_found)
		else $error("sync_found not a single search exit pulse");
	a_term_pulse: assert property (
		rx_terminated |-> rx_state == 2'h0 && $past(rx_state) == 2'h1 ##1 !rx_terminated)
		else $error("rx_terminated not a single search exit pulse");
	a_start_search: assert property (rx_state == 2'h0 && rx_start |=> rx_state == 2'h1)
		else $error("rx_start did not enter search");
	a_packet_next: assert property (
		rx_state == 2'h2 && packet_done
		|=> rx_state == ($past(post_receive_next_state) == 2'h3 ? 2'h1 : 2'h0))
		else $error("wrong state after packet");
	a_ook_quiet: assert property (
		$past(rstn) && $past(mod_format) == 3'h3 |-> !radio_cfg.dev_enable
		&& radio_cfg.dev_exponent == 3'h0 && radio_cfg.dev_mantissa == 3'h0)
		else $error("deviation active under on-off keying");
	a_fsk_dev: assert property (
		$past(rstn) && $past(mod_format) != 3'h3 |-> radio_cfg.dev_enable)
		else $error("deviation off outside on-off keying");
	c_found: cover property (sync_found);
	c_term: cover property (rx_terminated);
	c_stay: cover property (rx_state == 2'h2 && packet_done && post_receive_next_state == 2'h3);
endmodule
bind rcfg_top rcfg_top_monitor mon_u (.clk, .rstn, .csn, .miso, .miso_oe, .mod_format,
	.rx_start, .packet_done, .radio_cfg, .rx_state, .rx_on, .sync_found, .rx_terminated,
	.post_receive_next_state);
`default_nettype wire

/* File: test/rcfg_host_model.sv */
// Host microcontroller model driving serial register frames
`timescale 1ns/1ps
`default_nettype none
module rcfg_host_model (
	input wire logic clk, // System clock
	output logic csn, // Chip select, active low
	output logic sclk, // Serial clock
	output logic mosi, // Serial data to device
	input wire logic miso, // Serial data from device
	input wire logic miso_oe // Device drives miso
);
	initial begin
		csn = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Four clocks a phase, above the three-clock minimum
	task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			tick(4);
			sclk = 1'b1;
			tick(4);
			rx[i] = miso_oe ? miso : 1'bx;
			sclk = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
		logic [7:0] junk;
		csn = 1'b0;
		tick(4);
		byte_x(hdr, junk);
		byte_x(wd, rd);
		tick(4);
		csn = 1'b1;
		// Released line must not rest on the last bit
		mosi = ~mosi;
		tick(4);
	endtask
endmodule
`default_nettype wire

/* File: test/test_rcfg_top.sv */
// Self-checking bench for the radio configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_rcfg_top;
	logic clk, rstn, csn, sclk, mosi, miso, miso_oe, rx_start, demod_valid, demod_bit;
	logic carrier_sense, packet_done, rx_on, sync_found, rx_terminated;
	logic [2:0] sync_mode, mod_format;
	logic [31:0] sync_word = 32'hd391a5c3;
	logic [7:0] channel_number = 8'h05;
	logic [23:0] base_freq = 24'h123456;
	logic [25:0] synth_word;
	logic [1:0] rx_state, post_receive_next_state;
	rcfg_pkg::rcfg_radio_s radio_cfg;
	logic [7:0] msk [5] = '{8'h83, 8'hff, 8'h77, 8'h1f, 8'h3f};
	int failures = 0, compares = 0, nfound = 0, nterm = 0;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	rcfg_host_model host_u (.clk, .csn, .sclk, .mosi, .miso, .miso_oe);
	rcfg_top dut_u (.clk, .rstn, .csn, .sclk, .mosi, .miso, .miso_oe, .sync_mode, .mod_format,
		.sync_word, .channel_number, .base_freq, .rx_start, .demod_valid, .demod_bit,
		.carrier_sense, .packet_done, .radio_cfg, .synth_word, .rx_state, .rx_on,
		.sync_found, .rx_terminated, .post_receive_next_state);
	always @(posedge clk) begin
		if (sync_found === 1'b1) nfound++;
		if (rx_terminated === 1'b1) nterm++;
	end
	task automatic conclude();
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic rst(input int n);
		rstn = 1'b0;
		repeat (n) @(posedge clk);
		#1 rstn = 1'b1;
		step();
		step();
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] junk;
		host_u.frame({2'b00, a}, d, junk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] got;
		host_u.frame({2'b10, a}, 8'h00, got);
		check($sformatf("register %h", a), exp, got);
	endtask
	task automatic start();
		rx_start = 1'b1;
		step();
		rx_start = 1'b0;
	endtask
	// Shifts n low bits of sync_word out oldest first; err flips chosen bits
	task automatic feed(input int n, input logic [31:0] err);
		logic [31:0] v;
		v = sync_word ^ err;
		for (int i = n - 1; i >= 0; i--) begin
			demod_bit = v[i];
			demod_valid = 1'b1;
			step();
			demod_valid = 1'b0;
			step();
		end
	endtask
	task automatic sync_case(input logic [2:0] m, input logic cs, input int n,
		input logic [31:0] err, input logic hit);
		rst(2);
		sync_mode = m;
		carrier_sense = cs;
		nfound = 0;
		start();
		feed(n, err);
		step();
		step();
		check($sformatf("found mode %0d", m), hit, nfound);
		check("rx state", hit ? 2'h2 : 2'h1, rx_state);
	endtask
	task automatic pkt_end(input logic [1:0] exp);
		packet_done = 1'b1;
		step();
		packet_done = 1'b0;
		check("state after packet", exp, rx_state);
	endtask
	// Budget well above the frame and receive sequence below
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end
	initial begin
		{rstn, rx_start, demod_valid, demod_bit, carrier_sense, packet_done} = 6'h0;
		sync_mode = 3'h0;
		mod_format = 3'h0;
		rst(20);
		rd(6'h13, 8'h02);
		rd(6'h14, 8'hf8);
		rd(6'h15, 8'h47);
		rd(6'h16, 8'h07);
		rd(6'h17, 8'h30);
		check("radio", {2'h2, 8'hf8, 3'h4, 3'h7, 1'b1}, radio_cfg);
		check("synth", {base_freq, 2'b00} + 26'(((256 + 248) << 2) * 5), synth_word);
		for (int i = 0; i < 5; i++) begin
			wr(6'h13 + 6'(i), 8'hff);
			rd(6'h13 + 6'(i), msk[i]);
		end
		wr(6'h20, 8'hff);
		rd(6'h20, 8'h00);
		check("radio", {2'h3, 8'hff, 3'h7, 3'h7, 1'b1}, radio_cfg);
		check("synth", {base_freq, 2'b00} + 26'(((256 + 255) << 3) * 5), synth_word);
		mod_format = 3'h3;
		step();
		step();
		check("radio ook", {2'h3, 8'hff, 7'h0}, radio_cfg);
		mod_format = 3'h0;
		sync_case(3'h0, 1'b0, 0, 0, 1'b1);
		sync_case(3'h4, 1'b0, 16, 0, 1'b0);
		sync_case(3'h4, 1'b1, 0, 0, 1'b1);
		sync_case(3'h1, 1'b0, 16, 32'h0100, 1'b1);
		sync_case(3'h1, 1'b0, 16, 32'h0101, 1'b0);
		sync_case(3'h2, 1'b0, 16, 32'h0100, 1'b0);
		sync_case(3'h2, 1'b0, 16, 0, 1'b1);
		sync_case(3'h3, 1'b0, 32, 32'h80000001, 1'b1);
		sync_case(3'h3, 1'b0, 32, 32'h80010001, 1'b0);
		sync_case(3'h5, 1'b0, 16, 32'h0100, 1'b0);
		sync_case(3'h5, 1'b1, 16, 32'h0100, 1'b1);
		sync_case(3'h6, 1'b1, 16, 32'h0100, 1'b0);
		sync_case(3'h6, 1'b1, 16, 0, 1'b1);
		sync_case(3'h7, 1'b0, 32, 0, 1'b0);
		sync_case(3'h7, 1'b1, 32, 32'h00030000, 1'b1);
		wr(6'h17, 8'h3c);
		check("next state field", 2'h3, post_receive_next_state);
		pkt_end(2'h1);
		wr(6'h17, 8'h30);
		feed(32, 0);
		step();
		pkt_end(2'h0);
		rst(2);
		carrier_sense = 1'b0;
		wr(6'h16, 8'h17);
		nterm = 0;
		start();
		step();
		step();
		check("terminations", 1, nterm);
		check("rx state", 2'h0, rx_state);
		mod_format = 3'h3;
		start();
		feed(7, 32'hffffffff);
		check("ook before 8", 2'h1, rx_state);
		feed(1, 32'hffffffff);
		step();
		check("ook after 8", 2'h0, rx_state);
		check("terminations", 2, nterm);
		carrier_sense = 1'b1;
		start();
		feed(8, 32'hffffffff);
		step();
		check("ook carrier", 2'h1, rx_state);
		conclude();
	end
endmodule
`default_nettype wire
